/* inc/rcoc_pkg.sv */
// Constants, types and helpers shared by the read channel output control block
package rcoc_pkg;

  // ----------------------------------------------------------------
  // Register bus geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses, one word each)
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_CTRL_FIRST = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_CTRL_SECOND = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_IRQ_CLEAR = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_IRQ_ENABLE = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_LINE_STATE = 8'h14;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CA_W = 3;
  localparam int CA_SOFT_SECTOR = 0;
  localparam int CA_TP_SELECT = 1;
  localparam int CA_FREQ_EN = 2;
  localparam int CB_TP_ENABLE = 0;
  localparam int EV_W = 3;
  localparam int EV_ADDR_MARK = 0;
  localparam int EV_SYNC_FOUND = 1;
  localparam int EV_SRC_SWITCH = 2;

  // ----------------------------------------------------------------
  // Reset values and counts
  // ----------------------------------------------------------------
  localparam logic [CA_W-1:0] CTRL_FIRST_RST = 3'h0;
  localparam logic CTRL_SECOND_RST = 1'h0;
  localparam logic [EV_W-1:0] IRQ_ENABLE_RST = 3'h0;
  // Top of the synth half-period count; three half-periods per divided half
  localparam logic [1:0] DIV_HALF_MAX = 2'h2;

  // Source of the controller reference clock
  typedef enum logic {SRC_SYNTH, SRC_READ} rcoc_src_t;

  // Address match used by both read and write decode
  function automatic logic rcoc_hit(input logic [ADDR_W-1:0] a,
                                    input logic [ADDR_W-1:0] ofs);
    return a == ofs;
  endfunction

endpackage

/* src/rcoc_sync.sv */
// Three-flop pin synchroniser with agreement filter and edge pulses
`timescale 1ns/1ps
module rcoc_sync
  import rcoc_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_async, // Raw pin level
  output logic o_level, // Filtered level
  output logic o_rise, // One cycle before level goes high
  output logic o_fall // One cycle before level goes low
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic s1; // Metastability catcher, read only by s2
    logic s2;
    logic s3;
    logic stable; // Accepted level
  } rcoc_sync_st_t;

  rcoc_sync_st_t st_r;
  rcoc_sync_st_t st_nxt;
  logic agree;

  // Change accepted only once second and third stages agree
  assign agree = st_r.s2 == st_r.s3;

  // Next state
  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = i_async;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    if (agree) begin
      st_nxt.stable = st_r.s3;
    end
    if (i_rst) begin
      st_nxt = '0;
    end
  end

  // State register
  always_ff @(posedge i_clock) begin
    st_r <= st_nxt;
  end

  assign o_level = st_r.stable;
  assign o_rise = agree & st_r.s3 & ~st_r.stable;
  assign o_fall = agree & ~st_r.s3 & st_r.stable;

endmodule // rcoc_sync

/* src/rcoc_top.sv */
// Read channel output control: pin tristates, reference clock mux, write resync
`timescale 1ns/1ps
module rcoc_top
  import rcoc_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst,
  // Register port
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [DATA_W-1:0] i_wr_data,
  input wire logic i_wr_en,
  input wire logic i_rd_en,
  output logic [DATA_W-1:0] o_rd_data,
  output logic o_irq,
  // Controller gates and clocks (pins)
  input wire logic i_read_gate,
  input wire logic i_write_gate,
  input wire logic i_write_clock,
  input wire logic i_encoded_write,
  // Clocks sampled as pins
  input wire logic i_synth_ref_clock,
  input wire logic i_read_clock,
  // Internal channel logic, same clock
  input wire logic i_addr_mark_hit,
  input wire logic i_sync_found,
  input wire logic i_read_data,
  input wire logic i_delayed_read_pulse,
  input wire logic i_phase_ref_pulse,
  input wire logic i_above_pos_thr,
  input wire logic i_below_neg_thr,
  input wire logic i_zero_cross,
  // Pin outputs
  output logic o_address_mark_flag_n,
  output logic o_address_mark_flag_oe_n,
  output logic o_read_nrz,
  output logic o_read_nrz_oe_n,
  output logic o_ref_clock,
  output logic o_test_point_one,
  output logic o_test_point_one_oe_n,
  output logic o_test_point_two,
  output logic o_test_point_two_oe_n,
  output logic o_write_data,
  output logic o_synth_freq_test_out,
  output logic o_synth_freq_test_out_oe_n
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [DATA_W-1:0] rdata; // Read data, valid one cycle
    logic [CA_W-1:0] ctrl_a; // control_reg_first
    logic ctrl_b; // control_reg_second
    logic [EV_W-1:0] irq_en; // Interrupt enables
    logic [EV_W-1:0] status; // Sticky events
    logic am_flag; // Latched mark detect
    logic am_out_n;
    logic am_oe_n;
    logic nrz_data;
    logic nrz_oe_n;
    logic sync_seen; // Sync bits found this read
    logic [1:0] div_cnt; // Synth half-period count
    logic div_clk; // Synth divided by three
    rcoc_src_t src; // Reference clock source
    logic ref_clk;
    logic data_cmp; // Pulse qualifier data comparator
    logic clk_cmp; // Pulse qualifier clock comparator
    logic tp1;
    logic tp2;
    logic tp_oe_n;
    logic wr_hold; // Encoded bit on write clock side
    logic wr_bit; // Bit on synth clock side
    logic freq_out;
    logic freq_oe_n;
  } rcoc_st_t;

  rcoc_st_t st;
  rcoc_st_t st_nxt;
  logic [EV_W-1:0] ev_set; // Events raised this cycle
  logic [EV_W-1:0] ev_clr; // Clear strobe mask
  rcoc_src_t src_want; // Source the mode asks for
  logic am_search; // Soft sector search active

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic rg_level;
  logic wg_level;
  logic synth_level;
  logic synth_rise;
  logic synth_fall;
  logic rclk_level;
  logic wclk_rise;
  logic enc_level;

  // Read gate
  rcoc_sync u_sync_rg (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_async(i_read_gate),
    .o_level(rg_level),
    .o_rise(),
    .o_fall()
  );

  // Write gate
  rcoc_sync u_sync_wg (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_async(i_write_gate),
    .o_level(wg_level),
    .o_rise(),
    .o_fall()
  );

  // Synthesizer clock, both edges feed the divider
  rcoc_sync u_sync_synth (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_async(i_synth_ref_clock),
    .o_level(synth_level),
    .o_rise(synth_rise),
    .o_fall(synth_fall)
  );

  // Recovered read clock
  rcoc_sync u_sync_rclk (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_async(i_read_clock),
    .o_level(rclk_level),
    .o_rise(),
    .o_fall()
  );

  // Write timing input
  rcoc_sync u_sync_wclk (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_async(i_write_clock),
    .o_level(),
    .o_rise(wclk_rise),
    .o_fall()
  );

  // Encoded write data; its level lags the write clock rise pulse by one cycle, controller setup keeps them paired
  rcoc_sync u_sync_enc (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_async(i_encoded_write),
    .o_level(enc_level),
    .o_rise(),
    .o_fall()
  );

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  assign am_search = rg_level & st.ctrl_a[CA_SOFT_SECTOR];
  // Read clock only once sync bits are found in this read
  assign src_want = (rg_level && st.sync_seen) ? SRC_READ : SRC_SYNTH;
  assign ev_clr = (i_wr_en && rcoc_hit(i_addr, OFS_IRQ_CLEAR)) ?
                  i_wr_data[EV_W-1:0] : '0;

  always_comb begin
    st_nxt = st;
    ev_set = '0;

    // Register writes
    if (i_wr_en) begin
      if (rcoc_hit(i_addr, OFS_CTRL_FIRST)) begin
        st_nxt.ctrl_a = i_wr_data[CA_W-1:0];
      end else if (rcoc_hit(i_addr, OFS_CTRL_SECOND)) begin
        st_nxt.ctrl_b = i_wr_data[CB_TP_ENABLE];
      end else if (rcoc_hit(i_addr, OFS_IRQ_ENABLE)) begin
        st_nxt.irq_en = i_wr_data[EV_W-1:0];
      end
    end

    // Register reads, data stand one cycle only
    st_nxt.rdata = '0;
    if (i_rd_en) begin
      if (rcoc_hit(i_addr, OFS_CTRL_FIRST)) begin
        st_nxt.rdata = {29'h0, st.ctrl_a};
      end else if (rcoc_hit(i_addr, OFS_CTRL_SECOND)) begin
        st_nxt.rdata = {31'h0, st.ctrl_b};
      end else if (rcoc_hit(i_addr, OFS_IRQ_STATUS)) begin
        st_nxt.rdata = {29'h0, st.status};
      end else if (rcoc_hit(i_addr, OFS_IRQ_ENABLE)) begin
        st_nxt.rdata = {29'h0, st.irq_en};
      end else if (rcoc_hit(i_addr, OFS_LINE_STATE)) begin
        st_nxt.rdata = {27'h0, am_search, st.sync_seen,
                        st.src == SRC_READ, wg_level, rg_level};
      end
      // Unmapped and write-only offsets read as zero
    end

    // Address mark latch; gate release has priority over a new hit
    if (!rg_level) begin
      st_nxt.am_flag = 1'b0;
    end else if (am_search && i_addr_mark_hit) begin
      st_nxt.am_flag = 1'b1;
      ev_set[EV_ADDR_MARK] = ~st.am_flag;
    end
    st_nxt.am_out_n = ~st_nxt.am_flag;
    st_nxt.am_oe_n = wg_level;

    // Decoded read data driven only under read gate
    st_nxt.nrz_oe_n = ~rg_level;
    st_nxt.nrz_data = rg_level & i_read_data;

    // Sync tracking, restarts with each read gate
    if (!rg_level) begin
      st_nxt.sync_seen = 1'b0;
    end else if (i_sync_found) begin
      st_nxt.sync_seen = 1'b1;
      ev_set[EV_SYNC_FOUND] = ~st.sync_seen;
    end

    // Divide by three using both synth edges for even duty
    if (synth_rise || synth_fall) begin
      if (st.div_cnt == DIV_HALF_MAX) begin
        st_nxt.div_cnt = 2'h0;
        st_nxt.div_clk = ~st.div_clk;
      end else begin
        st_nxt.div_cnt = st.div_cnt + 2'h1;
      end
    end

    // Switch only with both sources low, so the output never slivers;
    // waiting for both lows costs at most one output pulse
    if (src_want != st.src && !st.div_clk && !rclk_level) begin
      st_nxt.src = src_want;
      ev_set[EV_SRC_SWITCH] = 1'b1;
    end
    st_nxt.ref_clk = (st.src == SRC_READ) ? rclk_level : st.div_clk;

    // Pulse qualifier comparators; upper threshold wins a tie
    if (i_above_pos_thr) begin
      st_nxt.data_cmp = 1'b1;
    end else if (i_below_neg_thr) begin
      st_nxt.data_cmp = 1'b0;
    end
    if (i_zero_cross) begin
      st_nxt.clk_cmp = ~st.clk_cmp;
    end

    // Test point multiplexers
    if (st.ctrl_a[CA_TP_SELECT]) begin
      st_nxt.tp1 = st.data_cmp;
      st_nxt.tp2 = st.clk_cmp;
    end else begin
      st_nxt.tp1 = i_delayed_read_pulse;
      st_nxt.tp2 = i_phase_ref_pulse;
    end
    st_nxt.tp_oe_n = ~st.ctrl_b;

    // Write path: catch on write clock, relaunch on synth clock.
    // Relies on the controller keeping data aligned to its clock.
    if (wclk_rise) begin
      st_nxt.wr_hold = enc_level;
    end
    if (synth_rise) begin
      st_nxt.wr_bit = st.wr_hold;
    end

    // Synth frequency test point
    st_nxt.freq_out = synth_level;
    st_nxt.freq_oe_n = ~st.ctrl_a[CA_FREQ_EN];

    // Sticky status, a new event beats a clear in the same cycle
    st_nxt.status = (st.status & ~ev_clr) | ev_set;

    // Synchronous reset: enabled outputs released; write data and reference clock stay driven
    if (i_rst) begin
      st_nxt = '0;
      st_nxt.ctrl_a = CTRL_FIRST_RST;
      st_nxt.ctrl_b = CTRL_SECOND_RST;
      st_nxt.irq_en = IRQ_ENABLE_RST;
      st_nxt.src = SRC_SYNTH;
      st_nxt.am_out_n = 1'b1;
      st_nxt.am_oe_n = 1'b1;
      st_nxt.nrz_oe_n = 1'b1;
      st_nxt.tp_oe_n = 1'b1;
      st_nxt.freq_oe_n = 1'b1;
    end
  end

  // State register
  always_ff @(posedge i_clock) begin
    st <= st_nxt;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign o_rd_data = st.rdata;
  assign o_irq = |(st.status & st.irq_en);
  assign o_address_mark_flag_n = st.am_out_n;
  assign o_address_mark_flag_oe_n = st.am_oe_n;
  assign o_read_nrz = st.nrz_data;
  assign o_read_nrz_oe_n = st.nrz_oe_n;
  assign o_ref_clock = st.ref_clk;
  assign o_test_point_one = st.tp1;
  assign o_test_point_one_oe_n = st.tp_oe_n;
  assign o_test_point_two = st.tp2;
  assign o_test_point_two_oe_n = st.tp_oe_n;
  // A one bit gives a falling edge; RLL spacing brings it back high
  assign o_write_data = ~st.wr_bit;
  assign o_synth_freq_test_out = st.freq_out;
  assign o_synth_freq_test_out_oe_n = st.freq_oe_n;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (i_rst);

  // Mark flag floats under write gate
  property p_am_float;
    wg_level |=> o_address_mark_flag_oe_n;
  endproperty
  a_am_float: assert property (p_am_float)
    else $error("mark flag driven under write gate");

  // Hit during search pulls flag low next cycle
  property p_am_set;
    (rg_level && st.ctrl_a[CA_SOFT_SECTOR] && i_addr_mark_hit)
      |=> !o_address_mark_flag_n;
  endproperty
  a_am_set: assert property (p_am_set)
    else $error("mark hit not flagged");

  // Latched flag holds while read gate stays
  property p_am_hold;
    (!o_address_mark_flag_n && rg_level) |=> !o_address_mark_flag_n;
  endproperty
  a_am_hold: assert property (p_am_hold)
    else $error("mark flag lost during read");

  // Gate release clears the flag
  property p_am_clear;
    !rg_level |=> o_address_mark_flag_n;
  endproperty
  a_am_clear: assert property (p_am_clear)
    else $error("mark flag not cleared");

  // Read output enable follows read gate
  property p_nrz_oe;
    !rg_level |=> (o_read_nrz_oe_n && !o_read_nrz);
  endproperty
  a_nrz_oe: assert property (p_nrz_oe)
    else $error("read output driven without gate");

  // Source changes only after both clocks were low
  property p_switch_low;
    $changed(st.src) |-> (!$past(st.div_clk) && !$past(rclk_level));
  endproperty
  a_switch_low: assert property (p_switch_low)
    else $error("clock source switched while high");

  // Reference output cannot rise in the cycle after a switch from low
  property p_no_glitch;
    $changed(st.src) |-> !o_ref_clock;
  endproperty
  a_no_glitch: assert property (p_no_glitch)
    else $error("reference clock glitch on switch");

  // Read clock only after sync bits
  property p_read_after_sync;
    $rose(st.src == SRC_READ) |-> $past(st.sync_seen) && $past(rg_level);
  endproperty
  a_read_after_sync: assert property (p_read_after_sync)
    else $error("read clock chosen before sync");

  // One enable for both test points
  property p_tp_enable;
    st.ctrl_b |=> (!o_test_point_one_oe_n && !o_test_point_two_oe_n);
  endproperty
  a_tp_enable: assert property (p_tp_enable)
    else $error("test points not enabled together");

  // Select low passes delayed read pulse
  property p_tp1_pulse;
    !st.ctrl_a[CA_TP_SELECT] |=> o_test_point_one == $past(i_delayed_read_pulse);
  endproperty
  a_tp1_pulse: assert property (p_tp1_pulse)
    else $error("test point one wrong source");

  // Positive threshold sets the data comparator, then shows on the pin
  property p_data_cmp;
    (i_above_pos_thr && st.ctrl_a[CA_TP_SELECT]) ##1 st.ctrl_a[CA_TP_SELECT]
      |=> o_test_point_one;
  endproperty
  a_data_cmp: assert property (p_data_cmp)
    else $error("data comparator did not rise");

  // Zero crossing toggles the clock comparator
  property p_clk_cmp;
    i_zero_cross |=> st.clk_cmp != $past(st.clk_cmp);
  endproperty
  a_clk_cmp: assert property (p_clk_cmp)
    else $error("clock comparator did not toggle");

  // Write output updates only on synth rising edges, inverted
  property p_write_resync;
    synth_rise |=> o_write_data == !$past(st.wr_hold);
  endproperty
  a_write_resync: assert property (p_write_resync)
    else $error("write data not relaunched");

  // Frequency test output off when its bit is clear
  property p_freq_oe;
    !st.ctrl_a[CA_FREQ_EN] |=> o_synth_freq_test_out_oe_n;
  endproperty
  a_freq_oe: assert property (p_freq_oe)
    else $error("frequency test output driven");

  // Main scenarios
  c_mark_found: cover property ($fell(o_address_mark_flag_n));
  c_to_read: cover property ($rose(st.src == SRC_READ));
  c_to_synth: cover property ($fell(st.src == SRC_READ));
  c_write_edge: cover property ($fell(o_write_data));

endmodule // rcoc_top

/* verification/rcoc_ctrl_model.sv */
// Disk controller side model: gates, write clock, encoded write and clocks
`timescale 1ns/1ps
module rcoc_ctrl_model (
  input wire logic i_clock,
  output logic o_read_gate,
  output logic o_write_gate,
  output logic o_write_clock,
  output logic o_encoded_write,
  output logic o_synth_ref_clock,
  output logic o_read_clock
);
  int sc; // Synth half-period count
  int rc; // Read clock half-period count
  initial begin
    o_read_gate = 1'b0;
    o_write_gate = 1'b0;
    o_write_clock = 1'b0;
    o_encoded_write = 1'b1;
    o_synth_ref_clock = 1'b0;
    o_read_clock = 1'b0;
    sc = 0;
    rc = 0;
  end
  // Synth clock free runs, three cycles a half
  always @(posedge i_clock) begin
    sc <= (sc == 2) ? 0 : sc + 1;
    if (sc == 2) o_synth_ref_clock <= ~o_synth_ref_clock;
  end
  // Recovered clock stands low outside read gate, five cycles a half
  always @(posedge i_clock) begin
    rc <= (rc == 4 || !o_read_gate) ? 0 : rc + 1;
    if (!o_read_gate) o_read_clock <= 1'b0;
    else if (rc == 4) o_read_clock <= ~o_read_clock;
  end
  // Gates change together after an edge
  task automatic set_gates(input logic rd, input logic wr);
    @(posedge i_clock);
    o_read_gate <= rd;
    o_write_gate <= wr;
  endtask
  // Data settles before the write clock rises, holds past its fall
  task automatic send_bit(input logic b);
    @(posedge i_clock);
    o_encoded_write <= b;
    repeat (3) @(posedge i_clock);
    o_write_clock <= 1'b1;
    repeat (4) @(posedge i_clock);
    o_write_clock <= 1'b0;
    repeat (3) @(posedge i_clock);
    o_encoded_write <= ~b; // Stale level not kept after hold
  endtask
endmodule // rcoc_ctrl_model

/* verification/rcoc_top_tb.sv */
// Self-checking bench for the read channel output control block
`timescale 1ns/1ps
module rcoc_top_tb;
  import rcoc_pkg::*;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic i_clock = 1'b0;
  logic rst = 1'b1;
  logic [ADDR_W-1:0] addr = 8'h00;
  logic [DATA_W-1:0] wdat = 32'h0;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic hit = 1'b0, sync = 1'b0, rdat = 1'b0, drp = 1'b0, prp = 1'b0;
  logic above = 1'b0, below = 1'b0, zc = 1'b0;
  logic [DATA_W-1:0] rd_data;
  logic irq, flag_n, flag_oe_n, nrz, nrz_oe_n, ref_clk, wdo, freq, freq_oe_n;
  logic tp_one, tp_one_oe_n, tp_two, tp_two_oe_n;
  logic rg, wg, wck, enc, sck, rck; // Controller pins
  int err_total = 0;
  int check_count = 0;
  always #4 i_clock = ~i_clock; // 125 MHz
  rcoc_ctrl_model ctl (.i_clock(i_clock), .o_read_gate(rg), .o_write_gate(wg),
    .o_write_clock(wck), .o_encoded_write(enc), .o_synth_ref_clock(sck),
    .o_read_clock(rck));
  rcoc_top dut (.i_clock(i_clock), .i_rst(rst), .i_addr(addr), .i_wr_data(wdat),
    .i_wr_en(wr_en), .i_rd_en(rd_en), .o_rd_data(rd_data), .o_irq(irq),
    .i_read_gate(rg), .i_write_gate(wg), .i_write_clock(wck), .i_encoded_write(enc),
    .i_synth_ref_clock(sck), .i_read_clock(rck), .i_addr_mark_hit(hit),
    .i_sync_found(sync), .i_read_data(rdat), .i_delayed_read_pulse(drp),
    .i_phase_ref_pulse(prp), .i_above_pos_thr(above), .i_below_neg_thr(below),
    .i_zero_cross(zc), .o_address_mark_flag_n(flag_n),
    .o_address_mark_flag_oe_n(flag_oe_n), .o_read_nrz(nrz), .o_read_nrz_oe_n(nrz_oe_n),
    .o_ref_clock(ref_clk), .o_test_point_one(tp_one), .o_test_point_one_oe_n(tp_one_oe_n),
    .o_test_point_two(tp_two), .o_test_point_two_oe_n(tp_two_oe_n), .o_write_data(wdo),
    .o_synth_freq_test_out(freq), .o_synth_freq_test_out_oe_n(freq_oe_n));
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Advance and land past the edge updates
  task automatic step(input int n);
    repeat (n) begin
      @(posedge i_clock);
      #1;
    end
  endtask
  task automatic check_bit(input string n, input logic e, input logic g);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s expected %b seen %b", n, e, g);
    end
  endtask
  task automatic check_word(input string n, input logic [DATA_W-1:0] e,
                            input logic [DATA_W-1:0] g);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  // One-cycle write strobe
  task automatic reg_wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge i_clock);
    wr_en <= 1'b1;
    addr <= a;
    wdat <= d;
    @(posedge i_clock);
    wr_en <= 1'b0;
  endtask
  // Data stands only in the cycle after the strobe
  task automatic reg_rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge i_clock);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge i_clock);
    rd_en <= 1'b0;
    #1;
    d = rd_data;
  endtask
  // Single-cycle pulse on one internal input: 0 hit, 1 sync, 2 above, 3 below, 4 crossing
  task automatic pulse(input int w);
    @(posedge i_clock);
    {zc, below, above, sync, hit} <= 5'h1 << w;
    @(posedge i_clock);
    {zc, below, above, sync, hit} <= 5'h0;
  endtask
  // Rising edges and shortest full run of the reference clock
  task automatic measure(input int n, output int rises, output int minw);
    logic prev;
    int run;
    step(1);
    prev = ref_clk;
    run = -1000; // First partial run is not a pulse
    rises = 0;
    minw = 1000;
    repeat (n) begin
      step(1);
      if (ref_clk !== prev) begin
        if (run > 0 && run < minw) minw = run;
        if (ref_clk === 1'b1) rises++;
        run = 1;
        prev = ref_clk;
      end else run++;
    end
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    logic [DATA_W-1:0] d;
    logic [ADDR_W-1:0] a [5];
    a = '{OFS_CTRL_FIRST, OFS_CTRL_SECOND, OFS_IRQ_STATUS, OFS_IRQ_ENABLE, 8'h40};
    step(1);
    check_bit("flag driven idle", 1'b0, flag_oe_n);
    check_bit("nrz float", 1'b1, nrz_oe_n);
    check_bit("tp float", 1'b1, tp_one_oe_n);
    check_bit("freq float", 1'b1, freq_oe_n);
    check_bit("write idle", 1'b1, wdo);
    foreach (a[i]) begin
      reg_rd(a[i], d);
      check_word("reset value", 32'h0, d);
    end
  endtask
  task automatic t_mark;
    logic [DATA_W-1:0] d;
    reg_wr(OFS_IRQ_CLEAR, 32'h7);
    ctl.set_gates(1'b1, 1'b0);
    step(8);
    pulse(0); // Mark hit, soft sector still off
    step(2);
    check_bit("mark ignored", 1'b1, flag_n);
    check_bit("flag driven", 1'b0, flag_oe_n);
    reg_wr(OFS_CTRL_FIRST, 32'h1);
    @(posedge i_clock);
    hit <= 1'b1;
    rdat <= 1'b1;
    @(posedge i_clock);
    hit <= 1'b0;
    rdat <= 1'b0;
    #1;
    check_bit("mark flag", 1'b0, flag_n);
    check_bit("nrz data", 1'b1, nrz);
    check_bit("nrz driven", 1'b0, nrz_oe_n);
    step(6);
    check_bit("mark latched", 1'b0, flag_n);
    check_bit("nrz follows", 1'b0, nrz);
    reg_wr(OFS_IRQ_STATUS, 32'h0); // Read-only, ignored
    reg_rd(OFS_IRQ_STATUS, d);
    check_word("mark status", 32'h1, d & 32'h1);
    check_bit("irq masked", 1'b0, irq);
    reg_wr(OFS_IRQ_ENABLE, 32'h1);
    step(1);
    check_bit("irq raised", 1'b1, irq);
    reg_wr(OFS_IRQ_CLEAR, 32'h1);
    step(1);
    check_bit("irq cleared", 1'b0, irq);
    ctl.set_gates(1'b0, 1'b0);
    for (int k = 0; k < 12 && flag_n !== 1'b1; k++) step(1);
    check_bit("mark released", 1'b1, flag_n);
    step(2);
    check_bit("nrz floats", 1'b1, nrz_oe_n);
  endtask
  task automatic t_write;
    ctl.set_gates(1'b0, 1'b1);
    for (int k = 0; k < 12 && flag_oe_n !== 1'b1; k++) step(1);
    check_bit("flag float in write", 1'b1, flag_oe_n);
    ctl.send_bit(1'b1);
    for (int k = 0; k < 20 && wdo !== 1'b0; k++) step(1);
    check_bit("write one falls", 1'b0, wdo);
    ctl.send_bit(1'b0);
    for (int k = 0; k < 20 && wdo !== 1'b1; k++) step(1);
    check_bit("write zero rises", 1'b1, wdo);
    ctl.set_gates(1'b0, 1'b0);
  endtask
  task automatic t_points;
    logic t;
    reg_wr(OFS_CTRL_SECOND, 32'h1);
    step(2);
    check_bit("tp one on", 1'b0, tp_one_oe_n);
    check_bit("tp two on", 1'b0, tp_two_oe_n);
    for (int i = 0; i < 2; i++) begin
      @(posedge i_clock);
      drp <= i[0];
      prp <= ~i[0];
      step(2);
      check_bit("tp one pulse", i[0], tp_one);
      check_bit("tp two ref", ~i[0], tp_two);
    end
    reg_wr(OFS_CTRL_FIRST, 32'h2);
    pulse(2); // Above positive threshold
    step(3);
    check_bit("comparator high", 1'b1, tp_one);
    pulse(3); // Below negative threshold
    step(3);
    check_bit("comparator low", 1'b0, tp_one);
    for (int i = 0; i < 2; i++) begin
      t = tp_two;
      pulse(4); // Zero crossing
      step(3);
      check_bit("clock comparator", ~t, tp_two);
    end
    reg_wr(OFS_CTRL_SECOND, 32'h0);
    step(2);
    check_bit("tp off", 1'b1, tp_two_oe_n);
  endtask
  task automatic t_freq;
    int n;
    logic p;
    reg_wr(OFS_CTRL_FIRST, 32'h4);
    step(3);
    check_bit("freq driven", 1'b0, freq_oe_n);
    n = 0;
    p = freq;
    repeat (60) begin
      step(1);
      if (freq !== p) n++;
      p = freq;
    end
    check_bit("freq rate", 1'b1, n >= 16 && n <= 24);
    reg_wr(OFS_CTRL_FIRST, 32'h0);
    step(3);
    check_bit("freq float", 1'b1, freq_oe_n);
  endtask
  task automatic t_refclk;
    int r;
    int w;
    logic [DATA_W-1:0] d;
    measure(180, r, w);
    check_bit("divide by three", 1'b1, r >= 9 && r <= 11 && w >= 8);
    reg_wr(OFS_IRQ_CLEAR, 32'h7);
    ctl.set_gates(1'b1, 1'b0);
    step(10);
    measure(100, r, w);
    check_bit("held before sync", 1'b1, r >= 5 && r <= 6 && w >= 8);
    pulse(1); // Sync bits found
    measure(200, r, w);
    check_bit("read clock taken", 1'b1, r >= 15);
    check_bit("no glitch", 1'b1, w >= 4);
    reg_rd(OFS_IRQ_STATUS, d);
    check_word("switch status", 32'h4, d & 32'h4);
    reg_rd(OFS_LINE_STATE, d);
    check_word("line state", 32'hd, d);
    ctl.set_gates(1'b0, 1'b0);
    step(40);
  endtask
  // ----------------------------------------------------------------
  // Run control
  // ----------------------------------------------------------------
  task automatic wrap_up;
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Main sequence after a 16-cycle reset
  initial begin
    repeat (16) @(posedge i_clock);
    rst <= 1'b0;
    t_reset;
    t_mark;
    t_write;
    t_points;
    t_freq;
    t_refclk;
    wrap_up;
  end
  // Watchdog, far beyond the roughly 800 cycles of the run
  initial begin
    repeat (20000) @(posedge i_clock);
    err_total++;
    wrap_up;
  end
endmodule // rcoc_top_tb
